// ### common/rpi_mem_if.sv
/*
  Carrier between the device top and its array memory.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface rpi_mem_if;
  logic [9:0]  addr;
  logic        we;
  logic [7:0]  wdata;
  logic [15:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface

// ### common/rpi_pkg.sv
/*
  Constants and types for the registered PROM with an initialize word.
  Assumes a single 100 MHz clock and programmer pins sampled synchronously.
*/
// Functional notes
// - extra byte beyond array loads register on init
// - unprogrammed extra byte reads as zero
// - supervoltage bit one, program-low bit two selects extra
// - blank check ones and zeros over 0..1023
// - output register loads on register clock rise, except the first rise after init, which keeps the init word
// - clock rise after init needed to enable outputs
package rpi_pkg;
  localparam int          ARRAY_WORDS = 1024;
  localparam int          ADDR_W      = 10;
  localparam int          DATA_W      = 8;
  localparam logic [7:0]  INIT_RESET  = 8'h00;
  localparam logic [7:0]  ONES_WORD   = 8'hFF;
  localparam logic [7:0]  ZEROS_WORD  = 8'h00;
  localparam logic [1:0]  CELL_BLANK  = 2'h0;
  localparam logic [1:0]  CELL_ZERO   = 2'h1;
  localparam logic [1:0]  CELL_ONE    = 2'h2;

  typedef enum logic [2:0] {
    RPI_READ     = 3'b000,
    RPI_INIT     = 3'b001,
    RPI_PROGRAM  = 3'b010,
    RPI_VERIFY   = 3'b011,
    RPI_PROG_INI = 3'b100,
    RPI_BLANK1   = 3'b101,
    RPI_BLANK0   = 3'b110,
    RPI_IDLE     = 3'b111
  } rpi_mode_t;
endpackage

// ### hw/rpi_cell_mem.sv
/*
  Differential cell array: two bits per data bit, blank when neither is set.
  Programming only adds cells; read data come out of a register.
*/
`timescale 1ns/1ps
module rpi_cell_mem
  import rpi_pkg::*;
#(
  parameter int WORDS = 1024
)
(
  input wire logic ref_clk,
  rpi_mem_if.mem   port
);
  logic [15:0] cell_q [WORDS];
  logic [15:0] rdata_q;
  logic [15:0] wr_cells;

  // each data bit drives its one or zero cell
  always_comb
  begin
    wr_cells = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      wr_cells[2*i+:2] = port.wdata[i] ? CELL_ONE : CELL_ZERO;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (port.we)
    begin
      cell_q[port.addr] <= cell_q[port.addr] | wr_cells;
    end
    rdata_q <= cell_q[port.addr];
  end

  initial
  begin
    for (int k = 0; k < WORDS; k++)
    begin
      cell_q[k] = '0;
    end
  end

  assign port.rdata = rdata_q;
endmodule

// ### hw/rpi_top.sv
/*
  Registered PROM device core: 1024-byte differential array, initialize word,
  output register on the register load clock, program, verify, blank check.
  Assumes pins are decoded to logic levels; supervoltage arrives as a flag.
*/
`timescale 1ns/1ps
module rpi_top
  import rpi_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic [rpi_pkg::ADDR_W-1:0] address,
  input  wire logic                      address_bit_one_vpp,
  input  wire logic                      address_bit_two_low,
  input  wire logic                      register_load_clock,
  input  wire logic                      sync_enable_n,
  input  wire logic                      init_n,
  input  wire logic                      output_enable_n,
  input  wire logic                      vpp_on,
  input  wire logic                      program_pulse_n,
  input  wire logic                      verify_n,
  input  wire logic                      blank_ones_sel,
  input  wire logic [rpi_pkg::DATA_W-1:0] data_in,
  output logic      [rpi_pkg::DATA_W-1:0] data_out,
  output logic                           data_oe
);
  import rpi_pkg::*;

  rpi_mem_if mif ();
  rpi_cell_mem #(.WORDS(ARRAY_WORDS)) u_mem (.ref_clk(ref_clk), .port(mif));

  logic [DATA_W-1:0] init_word_q, init_word_d;
  logic [DATA_W-1:0] out_reg_q, out_reg_d;
  logic [DATA_W-1:0] data_out_q, data_out_d;
  logic              oe_q, oe_d;
  logic              init_pend_q, init_pend_d;
  logic              sync_en_q, sync_en_d;
  logic              clk_prev_q;
  logic              prog_prev_q;
  logic              clk_rise;
  logic              prog_fall;
  rpi_mode_t         mode;

  function automatic logic [DATA_W-1:0] read_val(input logic [15:0] c, input logic ones);
    logic [DATA_W-1:0] v;
    v = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      // a blank cell reads one in ones mode and zero in zeros mode
      v[i] = ones ? (c[2*i+:2] != CELL_ZERO) : (c[2*i+:2] == CELL_ONE);
    end
    return v;
  endfunction

  assign clk_rise  = register_load_clock & ~clk_prev_q;
  assign prog_fall = ~program_pulse_n & prog_prev_q;

  always_comb
  begin
    if (vpp_on)
    begin
      if (address_bit_one_vpp && address_bit_two_low && !program_pulse_n)
        mode = RPI_PROG_INI;
      else if (register_load_clock)
        mode = blank_ones_sel ? RPI_BLANK1 : RPI_BLANK0;
      else if (!program_pulse_n)
        mode = RPI_PROGRAM;
      else if (!verify_n)
        mode = RPI_VERIFY;
      else
        mode = RPI_IDLE;
    end
    else if (!init_n && !output_enable_n)
      mode = RPI_INIT;
    else
      mode = RPI_READ;
  end

  assign mif.addr  = address;
  assign mif.wdata = data_in;
  assign mif.we    = (mode == RPI_PROGRAM) && prog_fall;

  always_comb
  begin
    init_word_d = init_word_q;
    out_reg_d   = out_reg_q;
    init_pend_d = init_pend_q;
    sync_en_d   = sync_en_q;
    data_out_d  = data_out_q;
    oe_d        = 1'b0;
    case (mode)
      RPI_PROG_INI:
      begin
        if (prog_fall)
          init_word_d = init_word_q | data_in;
      end
      RPI_INIT:
      begin
        out_reg_d   = init_word_q;
        init_pend_d = 1'b1;
      end
      RPI_VERIFY:
      begin
        data_out_d = read_val(mif.rdata, 1'b1);
        oe_d       = 1'b1;
      end
      RPI_BLANK1:
      begin
        data_out_d = read_val(mif.rdata, 1'b1);
        oe_d       = 1'b1;
      end
      RPI_BLANK0:
      begin
        data_out_d = read_val(mif.rdata, 1'b0);
        oe_d       = 1'b1;
      end
      RPI_READ:
      begin
        if (clk_rise)
        begin
          if (!init_pend_q)
            out_reg_d = read_val(mif.rdata, 1'b1);
          sync_en_d   = ~sync_enable_n;
          init_pend_d = 1'b0;
        end
        data_out_d = out_reg_d;
        oe_d       = sync_en_d && !init_pend_d && !output_enable_n;
      end
      default:
      begin
        oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      init_word_q <= INIT_RESET;
      out_reg_q   <= '0;
      data_out_q  <= '0;
      oe_q        <= 1'b0;
      init_pend_q <= 1'b0;
      sync_en_q   <= 1'b0;
      clk_prev_q  <= 1'b0;
      prog_prev_q <= 1'b1;
    end
    else
    begin
      init_word_q <= init_word_d;
      out_reg_q   <= out_reg_d;
      data_out_q  <= data_out_d;
      oe_q        <= oe_d;
      init_pend_q <= init_pend_d;
      sync_en_q   <= sync_en_d;
      clk_prev_q  <= register_load_clock;
      prog_prev_q <= program_pulse_n;
    end
  end

  assign data_out = data_out_q;
  assign data_oe  = oe_q;

  property p_init_loads;
    @(posedge ref_clk) disable iff (!rst_n)
      (mode == RPI_INIT) |=> (out_reg_q == $past(init_word_q));
  endproperty
  a_init_loads: assert property (p_init_loads) else $error("init word not loaded");

  property p_init_blocks_oe;
    @(posedge ref_clk) disable iff (!rst_n)
      (mode == RPI_INIT) |=> ##1 !data_oe;
  endproperty
  a_init_blocks_oe: assert property (p_init_blocks_oe) else $error("outputs on during init");

  property p_clock_loads;
    @(posedge ref_clk) disable iff (!rst_n)
      (mode == RPI_READ && clk_rise && !init_pend_q)
        |=> (out_reg_q == read_val($past(mif.rdata), 1'b1));
  endproperty
  a_clock_loads: assert property (p_clock_loads) else $error("register not loaded on clock");

  property p_extra_sel;
    @(posedge ref_clk) disable iff (!rst_n)
      (mode == RPI_PROG_INI) |-> !mif.we;
  endproperty
  a_extra_sel: assert property (p_extra_sel) else $error("array written on extra select");

  property p_blank0;
    @(posedge ref_clk) disable iff (!rst_n)
      (mode == RPI_BLANK0) |=> data_oe;
  endproperty
  a_blank0: assert property (p_blank0) else $error("blank check output off");

  sequence s_first_rise;
    (mode == RPI_READ) && clk_rise && init_pend_q;
  endsequence

  property p_init_kept;
    @(posedge ref_clk) disable iff (!rst_n)
      s_first_rise |=> (out_reg_q == $past(out_reg_q)) && !init_pend_q;
  endproperty
  a_init_kept: assert property (p_init_kept) else $error("init word lost on first clock");

  property p_extra_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (mode == RPI_PROG_INI && prog_fall)
        |=> (init_word_q == ($past(init_word_q) | $past(data_in)));
  endproperty
  a_extra_write: assert property (p_extra_write) else $error("extra byte not written");
endmodule

// ### testbench/rpi_prog_model.sv
/*
  Programmer model: drives every device input but ref_clk and rst_n, programs, verifies, blank checks.
  Assumes inputs change on falling ref_clk edges and the bench owns rst_n.
*/
`timescale 1ns/1ps
module rpi_prog_model
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic      [9:0] address,
  output logic      [7:0] data_in,
  output logic            address_bit_one_vpp,
  output logic            address_bit_two_low,
  output logic            register_load_clock,
  output logic            sync_enable_n,
  output logic            init_n,
  output logic            output_enable_n,
  output logic            vpp_on,
  output logic            program_pulse_n,
  output logic            verify_n,
  output logic            blank_ones_sel
);
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task idle;
    vpp_on = 0;
    init_n = 1;
    output_enable_n = 0;
    sync_enable_n = 0;
    program_pulse_n = 1;
    verify_n = 1;
    register_load_clock = 0;
    address_bit_one_vpp = 0;
    address_bit_two_low = 0;
    blank_ones_sel = 0;
    // data bus not held once a write ends
    data_in = ~data_in;
  endtask
  task automatic init(output logic [7:0] q, output logic p, output logic f);
    vpp_on = 0;
    address_bit_one_vpp = 0;
    address_bit_two_low = 0;
    output_enable_n = 0;
    init_n = 0;
    step(1);
    init_n = 1;
    step(1);
    p = data_oe;
    register_load_clock = 1;
    step(2);
    q = data_out;
    f = data_oe;
    register_load_clock = 0;
    step(1);
  endtask
  task automatic prog(input logic [9:0] a, input logic [7:0] d, input logic x,
                      output logic [7:0] q);
    logic p;
    logic f;
    vpp_on = 1;
    output_enable_n = 1;
    address = a;
    data_in = d;
    address_bit_one_vpp = x;
    address_bit_two_low = x;
    step(2);
    program_pulse_n = 0;
    step(2);
    program_pulse_n = 1;
    step(1);
    if (x)
      init(q, p, f);
    else
    begin
      verify_n = 0;
      step(2);
      q = data_out;
    end
    idle;
    step(1);
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] q);
    address = a;
    step(2);
    register_load_clock = 1;
    step(2);
    q = data_out;
    register_load_clock = 0;
    step(1);
  endtask
  task automatic blank(input logic o, input logic [9:0] a, output logic [7:0] q);
    vpp_on = 1;
    register_load_clock = 1;
    blank_ones_sel = o;
    verify_n = 0;
    address = a;
    step(3);
    q = data_out;
    idle;
    step(1);
  endtask
  initial
  begin
    data_in = 8'h00;
    address = 10'h000;
    idle;
  end
endmodule

// ### testbench/rpi_top_tb.sv
/*
  Self-checking bench for the registered PROM core.
  Assumes the programmer model drives all device inputs except ref_clk and rst_n.
*/
`timescale 1ns/1ps
module rpi_top_tb;
  import rpi_pkg::*;
  logic       ref_clk, rst_n, data_oe, p, f;
  logic [9:0] address;
  logic [7:0] data_in, data_out, q;
  logic       address_bit_one_vpp, address_bit_two_low, register_load_clock, sync_enable_n;
  logic       init_n, output_enable_n, vpp_on, program_pulse_n, verify_n, blank_ones_sel;
  int         error_cnt = 0;
  int         compares = 0;
  rpi_top rpi_top_inst (.ref_clk, .rst_n, .address, .address_bit_one_vpp,
    .address_bit_two_low, .register_load_clock, .sync_enable_n, .init_n,
    .output_enable_n, .vpp_on, .program_pulse_n, .verify_n, .blank_ones_sel,
    .data_in, .data_out, .data_oe);
  rpi_prog_model rpi_prog_model_inst (.ref_clk, .data_out, .data_oe, .address,
    .data_in, .address_bit_one_vpp, .address_bit_two_low, .register_load_clock,
    .sync_enable_n, .init_n, .output_enable_n, .vpp_on, .program_pulse_n,
    .verify_n, .blank_ones_sel);
  task print_verdict;
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task t_blank;
    for (int i = 0; i < ARRAY_WORDS; i++)
    begin
      rpi_prog_model_inst.blank(1'b1, i[9:0], q);
      chk("blank ones", ONES_WORD, q);
      rpi_prog_model_inst.blank(1'b0, i[9:0], q);
      chk("blank zeros", ZEROS_WORD, q);
    end
    $display("test blank done");
  endtask
  task t_prog_read;
    // ones and zeros both written so no cell stays ambiguous
    rpi_prog_model_inst.prog(10'h000, 8'hA5, 1'b0, q);
    chk("verify low", 8'hA5, q);
    rpi_prog_model_inst.prog(10'h3FF, 8'h3C, 1'b0, q);
    chk("verify high", 8'h3C, q);
    rpi_prog_model_inst.rd(10'h3FF, q);
    chk("read high", 8'h3C, q);
    rpi_prog_model_inst.rd(10'h000, q);
    chk("read low", 8'hA5, q);
    rpi_prog_model_inst.blank(1'b1, 10'h001, q);
    chk("neighbour blank", ONES_WORD, q);
    $display("test prog_read done");
  endtask
  task t_init(input logic [7:0] w);
    rpi_prog_model_inst.init(q, p, f);
    chk("oe before rise", 8'h00, {7'h00, p});
    chk("oe after rise", 8'h01, {7'h00, f});
    chk("init word", w, q);
    $display("test init done");
  endtask
  task t_extra;
    rpi_prog_model_inst.prog(10'h000, 8'h5A, 1'b1, q);
    chk("extra verify", 8'h5A, q);
    rpi_prog_model_inst.rd(10'h000, q);
    chk("array kept", 8'hA5, q);
    $display("test extra done");
  endtask
  initial
  begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    print_verdict;
  end
  initial
  begin
    rst_n = 0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1;
    chk("oe at reset", 8'h00, {7'h00, data_oe});
    t_blank;
    t_init(INIT_RESET);
    t_prog_read;
    t_init(INIT_RESET);
    t_extra;
    t_init(8'h5A);
    print_verdict;
  end
endmodule
